// file: verilog/acc_regbank.sv
// Register bank with burst pointer for the accelerometer map
`timescale 1ns/1ps
module acc_regbank (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	// Bus pins
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	input  wire logic        i_sa0,
	output logic             o_sda_o,
	output logic             o_sda_oe_n,
	// Samples and status from the sensing logic
	input  wire logic [13:0] i_x_sample,
	input  wire logic [13:0] i_y_sample,
	input  wire logic [13:0] i_z_sample,
	input  wire logic [7:0]  i_data_status,
	input  wire logic [7:0]  i_fifo_status,
	input  wire logic [7:0]  i_sys_mode,
	input  wire logic [7:0]  i_int_source,
	input  wire logic [7:0]  i_orient_status,
	input  wire logic [7:0]  i_fm_source,
	// Configuration to the sensing logic
	output logic [7:0]       o_fifo_setup,
	output logic [7:0]       o_trig_map,
	output logic [7:0]       o_range_cfg,
	output logic [7:0]       o_hp_cfg,
	output logic [7:0]       o_orient_cfg,
	output logic [7:0]       o_orient_deb,
	output logic [7:0]       o_bfz_cfg,
	output logic [7:0]       o_orient_ths,
	output logic [7:0]       o_fm_cfg,
	output logic [7:0]       o_fm_ths,
	output logic [7:0]       o_fm_deb,
	output logic [7:0]       o_trans_cfg,
	output logic [7:0]       o_ctrl1,
	output logic [3:0]       o_debounce_clr
);
	acc_regif_if bus_if ();

	logic [7:0] fifo_r, trig_r, range_r, hp_r, orc_r, ord_r, bfz_r, ort_r;
	logic [7:0] fmc_r, fmt_r, fmd_r, trc_r, ctl_r, ptr_r;
	logic [7:0] fifo_nxt, trig_nxt, range_nxt, hp_nxt, orc_nxt, ord_nxt, bfz_nxt, ort_nxt;
	logic [7:0] fmc_nxt, fmt_nxt, fmd_nxt, trc_nxt, ctl_nxt, ptr_nxt;
	logic [3:0] clr_r, clr_nxt;
	logic       fifo_on, fast_rd;

	acc_i2c_slave u_slave (
		.i_clk      (i_clk),
		.i_srst     (i_srst),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.i_sa0      (i_sa0),
		.o_sda_o    (o_sda_o),
		.o_sda_oe_n (o_sda_oe_n),
		.bus        (bus_if.slv)
	);

	// Burst pointer step; sample bytes follow the FIFO and fast read modes
	function automatic logic [7:0] acc_next_ptr(input logic [7:0] p, input logic fon,
		input logic fast);
		logic [7:0] n;
		n = p + 8'h01;
		case (p)
			acc_pkg::ADR_X_HIGH:
				n = fon ? acc_pkg::ADR_X_HIGH :
					(fast ? acc_pkg::ADR_Y_HIGH : acc_pkg::ADR_X_LOW);
			acc_pkg::ADR_Y_HIGH:
				n = !fast ? acc_pkg::ADR_Y_LOW :
					(fon ? acc_pkg::ADR_STATUS : acc_pkg::ADR_Z_HIGH);
			acc_pkg::ADR_X_LOW, acc_pkg::ADR_Y_LOW, acc_pkg::ADR_Z_HIGH:
				n = fast ? acc_pkg::ADR_STATUS : p + 8'h01;
			acc_pkg::ADR_Z_LOW:
				n = acc_pkg::ADR_STATUS;
			default: ;
		endcase
		return n;
	endfunction : acc_next_ptr

	assign fifo_on = |fifo_r[acc_pkg::FIFO_FIELD_LSB +: 2];
	assign fast_rd = ctl_r[acc_pkg::FAST_READ_BIT];

	// Read data for the byte at the pointer; unlisted addresses read zero
	always_comb
	begin
		case (ptr_r)
			acc_pkg::ADR_STATUS: bus_if.rdata = fifo_on ? i_fifo_status : i_data_status;
			acc_pkg::ADR_X_HIGH: bus_if.rdata = i_x_sample[13:6];
			acc_pkg::ADR_X_LOW: bus_if.rdata = {i_x_sample[5:0], 2'h0};
			acc_pkg::ADR_Y_HIGH: bus_if.rdata = i_y_sample[13:6];
			acc_pkg::ADR_Y_LOW: bus_if.rdata = {i_y_sample[5:0], 2'h0};
			acc_pkg::ADR_Z_HIGH: bus_if.rdata = i_z_sample[13:6];
			acc_pkg::ADR_Z_LOW: bus_if.rdata = {i_z_sample[5:0], 2'h0};
			acc_pkg::ADR_FIFO_SETUP: bus_if.rdata = fifo_r;
			acc_pkg::ADR_TRIG_MAP: bus_if.rdata = trig_r;
			acc_pkg::ADR_SYS_MODE: bus_if.rdata = i_sys_mode;
			acc_pkg::ADR_INT_SRC: bus_if.rdata = i_int_source;
			acc_pkg::ADR_DEV_ID: bus_if.rdata = acc_pkg::DEV_ID_VALUE;
			acc_pkg::ADR_RANGE: bus_if.rdata = range_r;
			acc_pkg::ADR_HP_CUT: bus_if.rdata = hp_r;
			acc_pkg::ADR_OR_STATUS: bus_if.rdata = i_orient_status;
			acc_pkg::ADR_OR_CFG: bus_if.rdata = orc_r;
			acc_pkg::ADR_OR_DEB: bus_if.rdata = ord_r;
			acc_pkg::ADR_BFZ_CFG: bus_if.rdata = bfz_r;
			acc_pkg::ADR_OR_THS: bus_if.rdata = ort_r;
			acc_pkg::ADR_FM_CFG: bus_if.rdata = fmc_r;
			acc_pkg::ADR_FM_SRC: bus_if.rdata = i_fm_source;
			acc_pkg::ADR_FM_THS: bus_if.rdata = fmt_r;
			acc_pkg::ADR_FM_DEB: bus_if.rdata = fmd_r;
			acc_pkg::ADR_TRANS_CFG: bus_if.rdata = trc_r;
			acc_pkg::ADR_CTRL1: bus_if.rdata = ctl_r;
			default: bus_if.rdata = 8'h00;
		endcase
	end

	// Register writes, debounce restarts and pointer movement
	always_comb
	begin
		{fifo_nxt, trig_nxt, range_nxt, hp_nxt} = {fifo_r, trig_r, range_r, hp_r};
		{orc_nxt, ord_nxt, bfz_nxt, ort_nxt} = {orc_r, ord_r, bfz_r, ort_r};
		{fmc_nxt, fmt_nxt, fmd_nxt, trc_nxt, ctl_nxt} = {fmc_r, fmt_r, fmd_r, trc_r, ctl_r};
		clr_nxt = 4'h0;
		ptr_nxt = ptr_r;
		if (bus_if.wr)
		begin
			case (ptr_r)
				acc_pkg::ADR_FIFO_SETUP: fifo_nxt = bus_if.wdata;
				acc_pkg::ADR_TRIG_MAP: trig_nxt = bus_if.wdata;
				acc_pkg::ADR_RANGE: range_nxt = bus_if.wdata;
				acc_pkg::ADR_HP_CUT: hp_nxt = bus_if.wdata;
				acc_pkg::ADR_OR_CFG: orc_nxt = bus_if.wdata;
				acc_pkg::ADR_OR_DEB: ord_nxt = bus_if.wdata;
				acc_pkg::ADR_BFZ_CFG: bfz_nxt = bus_if.wdata;
				acc_pkg::ADR_OR_THS: ort_nxt = bus_if.wdata;
				acc_pkg::ADR_FM_CFG: fmc_nxt = bus_if.wdata;
				acc_pkg::ADR_FM_THS: fmt_nxt = bus_if.wdata;
				acc_pkg::ADR_FM_DEB: fmd_nxt = bus_if.wdata;
				acc_pkg::ADR_TRANS_CFG: trc_nxt = bus_if.wdata;
				acc_pkg::ADR_CTRL1: ctl_nxt = bus_if.wdata;
				default: ; // Read-only and reserved bytes ignore writes
			endcase
			case (ptr_r)
				acc_pkg::ADR_FIFO_SETUP: clr_nxt[acc_pkg::DEB_FIFO] = 1'b1;
				acc_pkg::ADR_OR_DEB: clr_nxt[acc_pkg::DEB_OR] = 1'b1;
				acc_pkg::ADR_FM_THS: clr_nxt[acc_pkg::DEB_FM_TH] = 1'b1;
				acc_pkg::ADR_FM_DEB: clr_nxt[acc_pkg::DEB_FM_CT] = 1'b1;
				default: ;
			endcase
		end
		// Stop drops the pointer so no stale burst survives a transaction
		if (bus_if.stop)
			ptr_nxt = acc_pkg::ADR_STATUS;
		else if (bus_if.ptr_ld)
			ptr_nxt = bus_if.wdata;
		else if (bus_if.wr || bus_if.rd_next)
			ptr_nxt = acc_next_ptr(ptr_r, fifo_on, fast_rd);
	end

	// Register storage
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			{fifo_r, trig_r, range_r, hp_r} <= {4{acc_pkg::RST_ZERO}};
			orc_r <= acc_pkg::RST_OR_CFG;
			ord_r <= acc_pkg::RST_ZERO;
			bfz_r <= acc_pkg::RST_BFZ_CFG;
			ort_r <= acc_pkg::RST_OR_THS;
			{fmc_r, fmt_r, fmd_r, trc_r, ctl_r} <= {5{acc_pkg::RST_ZERO}};
			ptr_r <= acc_pkg::ADR_STATUS;
			clr_r <= 4'h0;
		end
		else
		begin
			{fifo_r, trig_r, range_r, hp_r} <= {fifo_nxt, trig_nxt, range_nxt, hp_nxt};
			{orc_r, ord_r, bfz_r, ort_r} <= {orc_nxt, ord_nxt, bfz_nxt, ort_nxt};
			{fmc_r, fmt_r, fmd_r, trc_r, ctl_r} <= {fmc_nxt, fmt_nxt, fmd_nxt, trc_nxt, ctl_nxt};
			ptr_r <= ptr_nxt;
			clr_r <= clr_nxt;
		end
	end

	assign {o_fifo_setup, o_trig_map, o_range_cfg, o_hp_cfg} = {fifo_r, trig_r, range_r, hp_r};
	assign {o_orient_cfg, o_orient_deb, o_bfz_cfg, o_orient_ths} = {orc_r, ord_r, bfz_r, ort_r};
	assign {o_fm_cfg, o_fm_ths, o_fm_deb, o_trans_cfg} = {fmc_r, fmt_r, fmd_r, trc_r};
	assign o_ctrl1 = ctl_r;
	assign o_debounce_clr = clr_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	logic rd_step;
	assign rd_step = bus_if.rd_next && !bus_if.stop;

	AST_FULL_WRAP: assert property (rd_step && ptr_r == 8'h06 |=> ptr_r == 8'h00)
		else $error("sample burst did not wrap to zero");
	AST_FIFO_HOLD: assert property (rd_step && ptr_r == 8'h01 && fifo_on
		|=> ptr_r == 8'h01)
		else $error("FIFO burst left the X high byte");
	AST_FAST_SKIP: assert property (rd_step && !fifo_on && fast_rd && ptr_r == 8'h01
		|=> ptr_r == 8'h03 ##0 !bus_if.rd_next [*1])
		else $error("fast burst did not skip the X low byte");
	AST_FAST_FIFO: assert property (rd_step && fifo_on && fast_rd && ptr_r inside {8'h03, 8'h05}
		|=> ptr_r == 8'h00)
		else $error("fast FIFO burst did not return to zero");
	AST_HIGH_BYTE: assert property (ptr_r == 8'h03 |-> bus_if.rdata == i_y_sample[13:6])
		else $error("high byte does not carry top sample bits");
	AST_LOW_BYTE: assert property (ptr_r == 8'h06
		|-> bus_if.rdata == {i_z_sample[5:0], 2'b00})
		else $error("low byte layout wrong");
	AST_RSV_ZERO: assert property (ptr_r inside {8'h07, 8'h08, [8'h19:8'h1C]}
		|-> bus_if.rdata == 8'h00)
		else $error("reserved byte read nonzero");
	AST_TRIG_WRITE: assert property (bus_if.wr && ptr_r == 8'h0A
		|=> o_trig_map == $past(bus_if.wdata))
		else $error("capture map write lost");
	AST_CFG_STEP: assert property ((bus_if.wr || rd_step) && ptr_r inside {[8'h09:8'h1C]}
		|=> ptr_r == $past(ptr_r) + 8'h01)
		else $error("config burst did not step by one");
	AST_RESET_VAL: assert property (disable iff (1'b0) $past(i_srst) |-> o_orient_cfg == 8'h80
		&& o_bfz_cfg == 8'h44 && o_orient_ths == 8'h84 && o_trig_map == 8'h00)
		else $error("reset values wrong");
	AST_STATUS_SEL: assert property (ptr_r == 8'h00 && fifo_on
		|-> bus_if.rdata == i_fifo_status)
		else $error("address zero ignores FIFO mode");
	AST_STOP_DROP: assert property (bus_if.stop |=> ptr_r == 8'h00 [*1])
		else $error("stop did not drop the pointer");
	AST_DEB_CLEAR: assert property (bus_if.wr && ptr_r == 8'h17
		|=> o_debounce_clr == 4'h4 ##1 o_debounce_clr == 4'h0)
		else $error("threshold write did not restart debounce");
endmodule : acc_regbank

// file: verilog/acc_pkg.sv
// Constants for the accelerometer register map and its serial slave
package acc_pkg;
	// Register addresses
	localparam logic [7:0] ADR_STATUS     = 8'h00;
	localparam logic [7:0] ADR_X_HIGH     = 8'h01;
	localparam logic [7:0] ADR_X_LOW      = 8'h02;
	localparam logic [7:0] ADR_Y_HIGH     = 8'h03;
	localparam logic [7:0] ADR_Y_LOW      = 8'h04;
	localparam logic [7:0] ADR_Z_HIGH     = 8'h05;
	localparam logic [7:0] ADR_Z_LOW      = 8'h06;
	localparam logic [7:0] ADR_RSV_07     = 8'h07;
	localparam logic [7:0] ADR_RSV_08     = 8'h08;
	localparam logic [7:0] ADR_FIFO_SETUP = 8'h09;
	localparam logic [7:0] ADR_TRIG_MAP   = 8'h0A;
	localparam logic [7:0] ADR_SYS_MODE   = 8'h0B;
	localparam logic [7:0] ADR_INT_SRC    = 8'h0C;
	localparam logic [7:0] ADR_DEV_ID     = 8'h0D;
	localparam logic [7:0] ADR_RANGE      = 8'h0E;
	localparam logic [7:0] ADR_HP_CUT     = 8'h0F;
	localparam logic [7:0] ADR_OR_STATUS  = 8'h10;
	localparam logic [7:0] ADR_OR_CFG     = 8'h11;
	localparam logic [7:0] ADR_OR_DEB     = 8'h12;
	localparam logic [7:0] ADR_BFZ_CFG    = 8'h13;
	localparam logic [7:0] ADR_OR_THS     = 8'h14;
	localparam logic [7:0] ADR_FM_CFG     = 8'h15;
	localparam logic [7:0] ADR_FM_SRC     = 8'h16;
	localparam logic [7:0] ADR_FM_THS     = 8'h17;
	localparam logic [7:0] ADR_FM_DEB     = 8'h18;
	localparam logic [7:0] ADR_RSV_19     = 8'h19;
	localparam logic [7:0] ADR_RSV_1C     = 8'h1C;
	localparam logic [7:0] ADR_TRANS_CFG  = 8'h1D;
	localparam logic [7:0] ADR_CTRL1      = 8'h2A;
	// Values after reset
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_OR_CFG     = 8'h80;
	localparam logic [7:0] RST_BFZ_CFG    = 8'h44;
	localparam logic [7:0] RST_OR_THS     = 8'h84;
	// Field positions
	localparam int FIFO_FIELD_LSB = 6;
	localparam int FAST_READ_BIT  = 1;
	// Debounce restart lanes
	localparam int DEB_FIFO  = 0;
	localparam int DEB_OR    = 1;
	localparam int DEB_FM_TH = 2;
	localparam int DEB_FM_CT = 3;
	// Upper six bits of the 7-bit slave address; strap pin gives bit 0
	localparam logic [5:0] SLAVE_ADR_HI = 6'h0E;
	// Identifier value is arbitrary
	localparam logic [7:0] DEV_ID_VALUE = 8'h5C;
endpackage : acc_pkg

// file: verilog/acc_regif_if.sv
// Internal link between the serial slave and the register bank
`timescale 1ns/1ps
interface acc_regif_if;
	logic       ptr_ld;   // First written byte: register address
	logic       wr;       // Later written byte: register data
	logic       rd_next;  // Read byte reached the rise of its ninth clock
	logic       stop;     // Stop condition seen
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport slv (output ptr_ld, output wr, output rd_next, output stop, output wdata,
		input rdata);
	modport bank (input ptr_ld, input wr, input rd_next, input stop, input wdata,
		output rdata);
endinterface : acc_regif_if

// file: verilog/acc_i2c_slave.sv
// Serial two-wire slave that turns bus traffic into register strobes
`timescale 1ns/1ps
module acc_i2c_slave (
	// Clock and reset
	input  wire logic  i_clk,
	input  wire logic  i_srst,
	// Bus pins
	input  wire logic  i_scl,
	input  wire logic  i_sda,
	input  wire logic  i_sa0,
	output logic       o_sda_o,
	output logic       o_sda_oe_n,
	// Register side
	acc_regif_if.slv   bus
);
	typedef enum logic [6:0] {
		S_IDLE = 7'h01, S_ADDR = 7'h02, S_ACKA = 7'h04, S_WBYTE = 7'h08,
		S_ACKW = 7'h10, S_RBYTE = 7'h20, S_RACK = 7'h40
	} acc_st_t;

	acc_st_t    st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic       rw_r, rw_nxt, first_r, first_nxt, mack_r, mack_nxt, oe_n_r, oe_n_nxt;
	logic       ld_r, ld_nxt, wr_r, wr_nxt, rdn_r, rdn_nxt, stop_r, stop_nxt;
	logic       scl_m, scl_s, scl_q, sda_m, sda_s, sda_q, sa0_m, sa0_s;
	logic       rise, fall, start_c, stop_c;

	// Pin synchronisers; the third stage only serves edge detection
	always_ff @(posedge i_clk)
	begin
		scl_m <= i_scl;
		scl_s <= scl_m;
		scl_q <= scl_s;
		sda_m <= i_sda;
		sda_s <= sda_m;
		sda_q <= sda_s;
		sa0_m <= i_sa0;
		sa0_s <= sa0_m;
	end

	// Bus events from synchronised levels
	assign rise    = scl_s & ~scl_q;
	assign fall    = ~scl_s & scl_q;
	assign start_c = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_c  = scl_s & scl_q & ~sda_q & sda_s;

	// Byte engine next state; stop and start win over any bit in flight
	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		rw_nxt = rw_r;
		first_nxt = first_r;
		mack_nxt = mack_r;
		oe_n_nxt = oe_n_r;
		ld_nxt = 1'b0;
		wr_nxt = 1'b0;
		rdn_nxt = 1'b0;
		stop_nxt = 1'b0;
		if (stop_c)
		begin
			st_nxt = S_IDLE;
			oe_n_nxt = 1'b1;
			stop_nxt = 1'b1;
		end
		else if (start_c)
		begin
			st_nxt = S_ADDR;
			cnt_nxt = 4'h0;
			oe_n_nxt = 1'b1;
			first_nxt = 1'b1;
		end
		else
		begin
			unique case (st_r)
				S_IDLE: ;
				S_ADDR, S_WBYTE:
					if (rise)
					begin
						sh_nxt = {sh_r[6:0], sda_s};
						cnt_nxt = cnt_r + 4'h1;
					end
					else if (fall && cnt_r == 4'h8)
					begin
						if (st_r == S_WBYTE)
						begin
							oe_n_nxt = 1'b0;
							st_nxt = S_ACKW;
							ld_nxt = first_r;
							wr_nxt = ~first_r;
						end
						else if (sh_r[7:1] == {acc_pkg::SLAVE_ADR_HI, sa0_s})
						begin
							oe_n_nxt = 1'b0;
							rw_nxt = sh_r[0];
							st_nxt = S_ACKA;
						end
						else
							st_nxt = S_IDLE;
					end
				S_ACKA, S_ACKW:
					if (fall)
					begin
						cnt_nxt = 4'h0;
						first_nxt = (st_r == S_ACKA) ? first_r : 1'b0;
						if (st_r == S_ACKA && rw_r)
						begin
							sh_nxt = bus.rdata;
							oe_n_nxt = bus.rdata[7];
							st_nxt = S_RBYTE;
						end
						else
						begin
							oe_n_nxt = 1'b1;
							st_nxt = S_WBYTE;
						end
					end
				S_RBYTE:
					if (rise)
						cnt_nxt = cnt_r + 4'h1;
					else if (fall)
					begin
						if (cnt_r == 4'h8)
						begin
							oe_n_nxt = 1'b1;
							st_nxt = S_RACK;
						end
						else
						begin
							sh_nxt = {sh_r[6:0], 1'b0};
							oe_n_nxt = sh_r[6];
						end
					end
				S_RACK:
					if (rise)
					begin
						rdn_nxt = 1'b1;
						mack_nxt = ~sda_s;
					end
					else if (fall)
					begin
						cnt_nxt = 4'h0;
						if (mack_r)
						begin
							sh_nxt = bus.rdata;
							oe_n_nxt = bus.rdata[7];
							st_nxt = S_RBYTE;
						end
						else
							st_nxt = S_IDLE;
					end
			endcase
		end
	end

	// Byte engine registers
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			st_r <= S_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			rw_r <= 1'b0;
			first_r <= 1'b0;
			mack_r <= 1'b0;
			oe_n_r <= 1'b1;
			ld_r <= 1'b0;
			wr_r <= 1'b0;
			rdn_r <= 1'b0;
			stop_r <= 1'b0;
			o_sda_o <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			rw_r <= rw_nxt;
			first_r <= first_nxt;
			mack_r <= mack_nxt;
			oe_n_r <= oe_n_nxt;
			ld_r <= ld_nxt;
			wr_r <= wr_nxt;
			rdn_r <= rdn_nxt;
			stop_r <= stop_nxt;
			o_sda_o <= 1'b0; // Open drain: only ever pulls low
		end
	end

	assign o_sda_oe_n  = oe_n_r;
	assign bus.ptr_ld  = ld_r;
	assign bus.wr      = wr_r;
	assign bus.rd_next = rdn_r;
	assign bus.stop    = stop_r;
	assign bus.wdata   = sh_r;
endmodule : acc_i2c_slave

// file: tb/acc_i2c_master.sv
// Bus master model for the two-wire register bus
`timescale 1ns/1ps
module acc_i2c_master (
	// Clock
	input  wire logic i_clk,
	// Bus pins, low or released
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda
);
	// Eight clocks per phase; the slave has no timeout, so slower phases also work
	localparam int HALF = 8;

	// Bus idles high through the pull-ups
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	// Whole clocks between pin changes
	task automatic hold(input int n);
		repeat (n) @(posedge i_clk);
	endtask : hold

	// Start or repeated start
	task automatic bus_start();
		o_sda <= 1'b1;
		hold(HALF);
		o_scl <= 1'b1;
		hold(HALF);
		o_sda <= 1'b0;
		hold(HALF);
		o_scl <= 1'b0;
		hold(HALF);
	endtask : bus_start

	// Stop, data rises while clock is high
	task automatic bus_stop();
		o_sda <= 1'b0;
		hold(HALF);
		o_scl <= 1'b1;
		hold(HALF);
		o_sda <= 1'b1;
		hold(HALF);
	endtask : bus_stop

	// One bit; sampled mid-high away from the edge to avoid races
	task automatic clk_bit(input logic b, output logic s);
		o_sda <= b;
		hold(HALF);
		o_scl <= 1'b1;
		hold(HALF / 2);
		@(negedge i_clk);
		s = i_sda;
		hold(HALF / 2);
		o_scl <= 1'b0;
		hold(2);
	endtask : clk_bit

	// Byte out, MSB first, then the acknowledge bit
	task automatic put_byte(input logic [7:0] b, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], s);
		clk_bit(1'b1, nak);
	endtask : put_byte

	// Byte in, then acknowledge or a closing NAK
	task automatic get_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, b[i]);
		clk_bit(last, s);
	endtask : get_byte
endmodule : acc_i2c_master

// file: tb/tb_accel_register_map_autoinc.sv
// Self-checking bench for the register map and burst pointer
`timescale 1ns/1ps
module tb_accel_register_map_autoinc;
	logic        clk;
	logic        srst;
	logic        sa0;
	logic [13:0] xs;
	logic [13:0] ys;
	logic [13:0] zs;
	logic [7:0]  st [6];
	logic [7:0]  shd [256];
	logic [7:0]  pc [4];
	logic [7:0]  trig, rng, ocfg, bfz, oths, fths, fdeb, ctl;
	logic [7:0]  fset, hpc, odeb, fmc, trc;
	logic [3:0]  dbc;
	logic        sda_o;
	logic        sda_oe_n;
	wire         scl;
	wire         m_sda;
	wire         sda;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;

	// Open-drain wire with pull-up
	assign sda = m_sda & (sda_oe_n | sda_o);

	acc_i2c_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));

	acc_regbank dut (
		.i_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda), .i_sa0(sa0),
		.o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
		.i_x_sample(xs), .i_y_sample(ys), .i_z_sample(zs),
		.i_data_status(st[0]), .i_fifo_status(st[1]), .i_sys_mode(st[2]),
		.i_int_source(st[3]), .i_orient_status(st[4]), .i_fm_source(st[5]),
		.o_fifo_setup(fset), .o_trig_map(trig), .o_range_cfg(rng), .o_hp_cfg(hpc),
		.o_orient_cfg(ocfg), .o_orient_deb(odeb), .o_bfz_cfg(bfz), .o_orient_ths(oths),
		.o_fm_cfg(fmc), .o_fm_ths(fths), .o_fm_deb(fdeb), .o_trans_cfg(trc),
		.o_ctrl1(ctl), .o_debounce_clr(dbc)
	);

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// Restart pulse tally and hang guard
	always @(posedge clk)
	begin
		for (int i = 0; i < 4; i++)
			if (dbc[i] === 1'b1)
				pc[i] <= pc[i] + 8'h01;
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			error_cnt++;
			test_done();
		end
	end

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask : chk1

	// Expected pointer step, worked out from the mode bits in the shadow
	function automatic logic [7:0] nxt(input logic [7:0] a);
		logic fon;
		logic fst;
		fon = shd[8'h09][7:6] != 2'b00;
		fst = shd[8'h2A][1];
		case (a)
			8'h01: nxt = fon ? 8'h01 : (fst ? 8'h03 : 8'h02);
			8'h02, 8'h04, 8'h05: nxt = fst ? 8'h00 : a + 8'h01;
			8'h03: nxt = !fst ? 8'h04 : (fon ? 8'h00 : 8'h05);
			8'h06: nxt = 8'h00;
			default: nxt = a + 8'h01;
		endcase
	endfunction : nxt

	// Expected read data at one address
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			8'h00: exp_rd = (shd[8'h09][7:6] != 2'b00) ? st[1] : st[0];
			8'h01: exp_rd = xs[13:6];
			8'h02: exp_rd = {xs[5:0], 2'b00};
			8'h03: exp_rd = ys[13:6];
			8'h04: exp_rd = {ys[5:0], 2'b00};
			8'h05: exp_rd = zs[13:6];
			8'h06: exp_rd = {zs[5:0], 2'b00};
			8'h0B: exp_rd = st[2];
			8'h0C: exp_rd = st[3];
			8'h0D: exp_rd = acc_pkg::DEV_ID_VALUE;
			8'h10: exp_rd = st[4];
			8'h16: exp_rd = st[5];
			default: exp_rd = shd[a];
		endcase
	endfunction : exp_rd

	// Start, write address, register pointer
	task automatic setp(input logic [7:0] a);
		logic k;
		m.bus_start();
		m.put_byte(8'h38, k);
		chk1(k, 1'b0);
		m.put_byte(a, k);
		chk1(k, 1'b0);
	endtask : setp

	// Burst write; shadow follows only the writable places
	task automatic wr(input logic [7:0] a, input logic [7:0] d [3], input int n);
		logic       k;
		logic [7:0] p;
		p = a;
		setp(a);
		for (int i = 0; i < n; i++)
		begin
			m.put_byte(d[i], k);
			chk1(k, 1'b0);
			if (p inside {8'h09, 8'h0A, 8'h0E, 8'h0F, 8'h11, 8'h12, 8'h13, 8'h14,
					8'h15, 8'h17, 8'h18, 8'h1D, 8'h2A})
				shd[p] = d[i];
			p = nxt(p);
		end
		m.bus_stop();
	endtask : wr

	// Burst read through a repeated start, each byte judged
	task automatic rd_chk(input logic [7:0] a, input int n);
		logic       k;
		logic [7:0] b;
		logic [7:0] p;
		p = a;
		setp(a);
		m.bus_start();
		m.put_byte(8'h39, k);
		chk1(k, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			m.get_byte(i == n - 1, b);
			chk8(b, exp_rd(p));
			p = nxt(p);
		end
		m.bus_stop();
	endtask : rd_chk

	task automatic out_chk();
		chk8(trig, shd[8'h0A]);
		chk8(rng, shd[8'h0E]);
		chk8(ocfg, shd[8'h11]);
		chk8(bfz, shd[8'h13]);
		chk8(oths, shd[8'h14]);
		chk8(fths, shd[8'h17]);
		chk8(fdeb, shd[8'h18]);
		chk8(ctl, shd[8'h2A]);
		chk8(fset, shd[8'h09]);
		chk8(hpc, shd[8'h0F]);
		chk8(odeb, shd[8'h12]);
		chk8(fmc, shd[8'h15]);
		chk8(trc, shd[8'h1D]);
	endtask : out_chk

	// Writes across writable, read-only and reserved places
	task automatic t_write();
		wr(8'h0A, '{8'h55, 8'hFF, 8'hFF}, 3);
		wr(8'h11, '{8'h0F, 8'h7E, 8'hC3}, 3);
		wr(8'h14, '{8'h21, 8'h99, 8'hFF}, 3);
		wr(8'h17, '{8'h12, 8'h34, 8'hAA}, 3);
		wr(8'h1C, '{8'hEE, 8'h6B, 8'h00}, 2);
		out_chk();
		rd_chk(8'h07, 23);
		chk8(pc[1], 8'h01);
		chk8(pc[2], 8'h01);
		chk8(pc[3], 8'h01);
	endtask : t_write

	// Every FIFO field value against both read widths
	task automatic t_modes();
		for (int f = 0; f < 8; f++)
		begin
			wr(8'h09, '{{f[1:0], 6'h00}, 8'h00, 8'h00}, 1);
			wr(8'h2A, '{{6'h00, f[2], 1'b0}, 8'h00, 8'h00}, 1);
			out_chk();
			rd_chk(8'h00, 8);
			rd_chk(8'h03, 2);
			rd_chk(8'h05, 2);
		end
		wr(8'h09, '{8'h00, 8'h00, 8'h00}, 1);
		wr(8'h2A, '{8'h00, 8'h00, 8'h00}, 1);
		chk8(pc[0], 8'h09);
	endtask : t_modes

	// Pointer set, stop, then a bare read starts at zero
	task automatic t_stop();
		logic [7:0] b;
		logic       k;
		wr(8'h0E, '{8'h5A, 8'h00, 8'h00}, 1);
		setp(8'h0E);
		m.bus_stop();
		m.bus_start();
		m.put_byte(8'h39, k);
		chk1(k, 1'b0);
		m.get_byte(1'b1, b);
		m.bus_stop();
		chk8(b, exp_rd(8'h00));
	endtask : t_stop

	// Strap moves the slave address; the old one goes unanswered
	task automatic t_addr();
		logic k;
		sa0 <= 1'b1;
		m.hold(8);
		m.bus_start();
		m.put_byte(8'h38, k);
		chk1(k, 1'b1);
		m.bus_stop();
		m.bus_start();
		m.put_byte(8'h3A, k);
		chk1(k, 1'b0);
		m.bus_stop();
		sa0 <= 1'b0;
		m.hold(8);
	endtask : t_addr

	// Main sequence
	initial
	begin
		clk = 1'b0;
		srst = 1'b1;
		sa0 = 1'b0;
		xs = 14'h2_ABC;
		ys = 14'h1_357;
		zs = 14'h3_F0F;
		st = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
		pc = '{default: 8'h00};
		shd = '{default: 8'h00};
		shd[8'h11] = 8'h80;
		shd[8'h13] = 8'h44;
		shd[8'h14] = 8'h84;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		m.hold(8);
		out_chk();
		rd_chk(8'h07, 23);
		rd_chk(8'h2A, 1);
		t_write();
		t_modes();
		t_stop();
		t_addr();
		test_done();
	end
endmodule : tb_accel_register_map_autoinc
